// *** cts_pkg.sv ***
package cts_pkg;
    // register indices (word offsets), byte address = index * 4
    localparam logic [3:0] CTS_IDX_SENSE_A = 4'h0;
    localparam logic [3:0] CTS_IDX_SENSE_B = 4'h1;
    localparam logic [3:0] CTS_IDX_T1_CTRL = 4'h2;
    localparam logic [3:0] CTS_IDX_T1_GATE = 4'h3;
    localparam logic [3:0] CTS_IDX_T1_COUNT = 4'h4;
    localparam logic [3:0] CTS_IDX_T0_COUNT = 4'h5;
    localparam logic [3:0] CTS_IDX_T0_OPT = 4'h6;
    localparam logic [3:0] CTS_IDX_PIN_CFG = 4'h7;
    localparam int CTS_ADDR_W = 6;
    // sense_control_a fields
    localparam int CTS_A_ENABLE = 7;
    localparam int CTS_A_RANGE_LO = 2;
    localparam int CTS_A_PHASE = 1;
    localparam int CTS_A_TIMER0_EXTERNAL_SOURCE_SELECT = 0;
    // timer1_control fields
    localparam int CTS_T1_CS_LO = 6;
    localparam int CTS_T1_ON = 0;
    // timer1_gate_control fields
    localparam int CTS_G_ENABLE = 7;
    localparam int CTS_G_TOGGLE = 5;
    localparam int CTS_G_VALUE = 2;
    localparam int CTS_G_SRC_LO = 0;
    // timer0 option field
    localparam int CTS_T0_CS = 0;
    localparam logic [1:0] CTS_T1CS_OSC = 2'h3;
    localparam logic [1:0] CTS_GSRC_PIN = 2'h0;
    localparam logic [1:0] CTS_GSRC_T0 = 2'h1;
    localparam logic [1:0] CTS_GSRC_T2 = 2'h2;
    localparam logic [1:0] CTS_GSRC_WDT = 2'h3;
    localparam logic [1:0] CTS_RNG_OFF = 2'h0;
    localparam logic [7:0] CTS_T0_OPT_RESET = 8'h01;
    localparam int CTS_CHANNELS = 16;
    typedef enum logic [1:0] {
        CTS_BUS_IDLE,
        CTS_BUS_DONE
    } cts_bus_state_type;
endpackage : cts_pkg

// *** cts_touch_sense.sv ***
// Summary of operation
// - sixteen-way pad mux, channel-select field
// - enabled: oscillator routed to selected pad
// - readable flag: oscillator sourcing or sinking
// - two-bit range field sets oscillator current
// - external select, clock bit clear: osc clocks timer0
// - timer1 source field 11: osc clocks timer1
// - timer1 off unless on; gate gates counting
// - timer count equals oscillator cycles in window
// - oscillator runs in sleep while enabled
// - timer0 does not count in sleep
// - watchdog toggle: first starts, second stops
// - range 00 off, 01 low, 10 mid, 11 high
// - disabled: channel ignored, no pad connected
// - gate source 11 selects watchdog overflow
module cts_touch_sense
    import cts_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [cts_pkg::CTS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // analog front end
    input wire logic osc_in,
    input wire logic osc_phase_in,
    output logic osc_enable,
    output logic [1:0] osc_range,
    output logic [15:0] pad_select,
    // system events
    input wire logic sleep_mode,
    input wire logic t0_ext_pin,
    input wire logic t1_gate_pin,
    input wire logic t0_overflow,
    input wire logic t2_match,
    input wire logic wdt_overflow,
    // timer clock enables out
    output logic t0_count_en,
    output logic t1_count_en
);
    import cts_pkg::*;

    typedef struct packed {
        cts_bus_state_type bus;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic [7:0] sense_a;
        logic [3:0] chan;
        logic [7:0] t1_ctrl;
        logic [7:0] t1_gate;
        logic [7:0] t0_opt;
        logic [15:0] t1_count;
        logic [7:0] t0_count;
        logic [15:0] pin_cfg;
        logic [1:0] osc_sync;
        logic osc_prev;
        logic [1:0] phase_sync;
        logic [1:0] t0pin_sync;
        logic t0pin_prev;
        logic [1:0] gpin_sync;
        logic gate_src_prev;
        logic gate_toggle_q;
        logic t0_tick;
        logic t1_tick;
        logic [15:0] pad_q;
        logic osc_en_q;
        logic [1:0] range_q;
    } cts_state_type;

    cts_state_type state_reg;
    cts_state_type state_next;

    function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic lane);
        merge_byte = lane ? new_v : old_v;
    endfunction

    function automatic logic [15:0] one_hot16(input logic [3:0] idx);
        one_hot16 = 16'h0001 << idx;
    endfunction

    // bus answer codes and writable-bit masks
    localparam logic [1:0] CTS_RESP_OK = 2'h0;
    localparam logic [1:0] CTS_RESP_ERR = 2'h2;
    localparam logic [7:0] CTS_A_WMASK = 8'h8d;
    localparam logic [7:0] CTS_T1_WMASK = 8'hfd;

    // two-flop synchroniser shift
    function automatic logic [1:0] sync2(input logic [1:0] chain,
                                         input logic pin);
        sync2 = {chain[0], pin};
    endfunction

    // edge detect on a synchronised level
    function automatic logic rise_of(input logic cur,
                                     input logic prev);
        rise_of = cur & ~prev;
    endfunction

    // two byte lanes of a 16-bit register
    function automatic logic [15:0] merge_half(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0] lanes);
        merge_half = {merge_byte(old_v[15:8], new_v[15:8], lanes[1]),
                      merge_byte(old_v[7:0], new_v[7:0], lanes[0])};
    endfunction

    // timer1 enable table: off, free run, or gated
    function automatic logic t1_runs(input logic run_bit,
                                     input logic gate_en,
                                     input logic gate_ok);
        case ({run_bit, gate_en})
            2'h2: t1_runs = 1'b1;
            2'h3: t1_runs = gate_ok;
            default: t1_runs = 1'b0;
        endcase
    endfunction

    // index decode for the response code only
    function automatic logic is_mapped(input logic [3:0] i);
        case (i)
            CTS_IDX_SENSE_A,
            CTS_IDX_SENSE_B,
            CTS_IDX_T1_CTRL,
            CTS_IDX_T1_GATE,
            CTS_IDX_T1_COUNT,
            CTS_IDX_T0_COUNT,
            CTS_IDX_T0_OPT,
            CTS_IDX_PIN_CFG: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // read word for an index, phase taken live from the synchroniser
    function automatic logic [31:0] read_word(input cts_state_type s,
                                              input logic [3:0] i);
        read_word = 32'h0;
        case (i)
            CTS_IDX_SENSE_A: begin
                read_word[7:0] = {s.sense_a[7:2], s.phase_sync[1], s.sense_a[0]};
            end
            CTS_IDX_SENSE_B: begin
                read_word[3:0] = s.chan;
            end
            CTS_IDX_T1_CTRL: begin
                read_word[7:0] = s.t1_ctrl;
            end
            CTS_IDX_T1_GATE: begin
                read_word[7:0] = s.t1_gate;
            end
            CTS_IDX_T1_COUNT: begin
                read_word[15:0] = s.t1_count;
            end
            CTS_IDX_T0_COUNT: begin
                read_word[7:0] = s.t0_count;
            end
            CTS_IDX_T0_OPT: begin
                read_word[7:0] = s.t0_opt;
            end
            CTS_IDX_PIN_CFG: begin
                read_word[15:0] = s.pin_cfg;
            end
            default: begin
                read_word = 32'h0;
            end
        endcase
    endfunction

    logic [3:0] idx;
    logic enabled;
    logic osc_rise;
    logic t0_src_osc;
    logic t0_src_pin;
    logic t1_src_osc;
    logic gate_raw;
    logic gate_edge;
    logic gate_open;
    logic wr_t1cnt;
    logic wr_t0cnt;
    logic t0pin_rise;
    logic t1_ok;

    always_comb begin
        state_next = state_reg;
        idx = avs_address[CTS_ADDR_W-1:2];
        enabled = state_reg.sense_a[CTS_A_ENABLE];
        // second sync stage only feeds the edge detector
        osc_rise = rise_of(state_reg.osc_sync[1], state_reg.osc_prev);
        t0pin_rise = rise_of(state_reg.t0pin_sync[1], state_reg.t0pin_prev);
        t0_src_osc = state_reg.sense_a[CTS_A_TIMER0_EXTERNAL_SOURCE_SELECT] & ~state_reg.t0_opt[CTS_T0_CS];
        t0_src_pin = state_reg.t0_opt[CTS_T0_CS] & ~state_reg.sense_a[CTS_A_TIMER0_EXTERNAL_SOURCE_SELECT];
        t1_src_osc = (state_reg.t1_ctrl[CTS_T1_CS_LO +: 2] == CTS_T1CS_OSC);
        case (state_reg.t1_gate[CTS_G_SRC_LO +: 2])
            CTS_GSRC_PIN: gate_raw = state_reg.gpin_sync[1];
            CTS_GSRC_T0: gate_raw = t0_overflow;
            CTS_GSRC_T2: gate_raw = t2_match;
            CTS_GSRC_WDT: gate_raw = wdt_overflow;
            default: gate_raw = 1'b0;
        endcase
        gate_edge = rise_of(gate_raw, state_reg.gate_src_prev);
        gate_open = state_reg.t1_gate[CTS_G_TOGGLE] ? state_reg.gate_toggle_q : gate_raw;
        wr_t1cnt = 1'b0;
        wr_t0cnt = 1'b0;

        // synchronisers
        state_next.osc_sync = sync2(state_reg.osc_sync, osc_in);
        state_next.osc_prev = state_reg.osc_sync[1];
        state_next.phase_sync = sync2(state_reg.phase_sync, osc_phase_in);
        state_next.t0pin_sync = sync2(state_reg.t0pin_sync, t0_ext_pin);
        state_next.t0pin_prev = state_reg.t0pin_sync[1];
        state_next.gpin_sync = sync2(state_reg.gpin_sync, t1_gate_pin);
        state_next.gate_src_prev = gate_raw;

        // toggle gate: each rising source edge flips the window
        // a late source edge simply holds the window open longer
        if (!state_reg.t1_gate[CTS_G_TOGGLE] || !state_reg.t1_gate[CTS_G_ENABLE]) begin
            state_next.gate_toggle_q = 1'b0;
        end else if (gate_edge) begin
            state_next.gate_toggle_q = ~state_reg.gate_toggle_q;
        end
        state_next.t1_gate[CTS_G_VALUE] = gate_open;

        // bus slave, one wait cycle then answer
        case (state_reg.bus)
            CTS_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    state_next.bus = CTS_BUS_DONE;
                    state_next.resp = is_mapped(idx) ? CTS_RESP_OK : CTS_RESP_ERR;
                    state_next.rdata = read_word(state_reg, idx);
                    if (avs_write) begin
                        case (idx)
                            CTS_IDX_SENSE_A: begin
                                state_next.sense_a = merge_byte(state_reg.sense_a,
                                    avs_writedata[7:0] & CTS_A_WMASK, avs_byteenable[0]);
                            end
                            CTS_IDX_SENSE_B: begin
                                if (avs_byteenable[0]) begin
                                    state_next.chan = avs_writedata[3:0];
                                end
                            end
                            CTS_IDX_T1_CTRL: begin
                                state_next.t1_ctrl = merge_byte(state_reg.t1_ctrl,
                                    avs_writedata[7:0] & CTS_T1_WMASK, avs_byteenable[0]);
                            end
                            CTS_IDX_T1_GATE: begin
                                if (avs_byteenable[0]) begin
                                    state_next.t1_gate = {avs_writedata[7:3], gate_open,
                                                          avs_writedata[1:0]};
                                end
                            end
                            CTS_IDX_T1_COUNT: begin
                                wr_t1cnt = 1'b1;
                                state_next.t1_count = merge_half(state_reg.t1_count,
                                    avs_writedata[15:0], avs_byteenable[1:0]);
                            end
                            CTS_IDX_T0_COUNT: begin
                                wr_t0cnt = avs_byteenable[0];
                                state_next.t0_count = merge_byte(state_reg.t0_count,
                                    avs_writedata[7:0], avs_byteenable[0]);
                            end
                            CTS_IDX_T0_OPT: begin
                                state_next.t0_opt = merge_byte(state_reg.t0_opt,
                                    avs_writedata[7:0], avs_byteenable[0]);
                            end
                            CTS_IDX_PIN_CFG: begin
                                state_next.pin_cfg = merge_half(state_reg.pin_cfg,
                                    avs_writedata[15:0], avs_byteenable[1:0]);
                            end
                            default: begin
                                state_next.pin_cfg = state_reg.pin_cfg;
                            end
                        endcase
                    end
                end
            end
            CTS_BUS_DONE: state_next.bus = CTS_BUS_IDLE;
            default: state_next.bus = CTS_BUS_IDLE;
        endcase

        // timer1: on bit, gate enable, oscillator source
        state_next.t1_tick = 1'b0;
        t1_ok = t1_runs(state_reg.t1_ctrl[CTS_T1_ON], state_reg.t1_gate[CTS_G_ENABLE],
                        gate_open);
        if (t1_ok && t1_src_osc && osc_rise) begin
            state_next.t1_tick = 1'b1;
            if (!wr_t1cnt) begin
                state_next.t1_count = state_reg.t1_count + 16'h0001;
            end
        end

        // timer0 halts in sleep
        state_next.t0_tick = 1'b0;
        if (!sleep_mode) begin
            if ((t0_src_osc && osc_rise) ||
                (t0_src_pin && t0pin_rise)) begin
                state_next.t0_tick = 1'b1;
                if (!wr_t0cnt) begin
                    state_next.t0_count = state_reg.t0_count + 8'h01;
                end
            end
        end

        // analog control, independent of sleep
        state_next.osc_en_q = enabled && (state_reg.sense_a[CTS_A_RANGE_LO +: 2] != CTS_RNG_OFF);
        state_next.range_q = enabled ? state_reg.sense_a[CTS_A_RANGE_LO +: 2] : CTS_RNG_OFF;
        state_next.pad_q = enabled ? one_hot16(state_reg.chan) : 16'h0000;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '{bus: CTS_BUS_IDLE, t0_opt: CTS_T0_OPT_RESET, default: '0};
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        avs_waitrequest = (avs_read || avs_write) && (state_reg.bus != CTS_BUS_DONE);
        avs_readdata = state_reg.rdata;
        avs_response = state_reg.resp;
        osc_enable = state_reg.osc_en_q;
        osc_range = state_reg.range_q;
        pad_select = state_reg.pad_q;
        t0_count_en = state_reg.t0_tick;
        t1_count_en = state_reg.t1_tick;
    end
endmodule // cts_touch_sense

// *** cts_touch_sense_checker.sv ***
module cts_touch_sense_checker (
    // clock, reset
    input wire logic clk,
    input wire logic rst_b,
    // observed ports
    input wire logic avs_write,
    input wire logic sleep_mode,
    input wire logic osc_enable,
    input wire logic [1:0] osc_range,
    input wire logic [15:0] pad_select,
    input wire logic t0_count_en,
    input wire logic t1_count_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_pad_hot; $onehot0(pad_select); endproperty
    a_pad_hot: assert property (p_pad_hot) else $error("pad select not one-hot");
    property p_en_rng; osc_enable == (osc_range != 2'h0); endproperty
    a_en_rng: assert property (p_en_rng) else $error("osc enable and range disagree");
    property p_run_pad; osc_range != 2'h0 |-> $onehot(pad_select); endproperty
    a_run_pad: assert property (p_run_pad) else $error("running osc without pad");
    property p_pad_cause; $changed(pad_select) |-> $past(avs_write) || $past(avs_write, 2);
    endproperty
    a_pad_cause: assert property (p_pad_cause) else $error("pad changed without write");
    property p_rng_cause; $changed(osc_range) |-> $past(avs_write) || $past(avs_write, 2);
    endproperty
    a_rng_cause: assert property (p_rng_cause) else $error("range changed without write");
    property p_sleep_t0; sleep_mode [*3] |-> !t0_count_en; endproperty
    a_sleep_t0: assert property (p_sleep_t0) else $error("timer0 counted in sleep");
    property p_t1_pulse; t1_count_en |=> !t1_count_en; endproperty
    a_t1_pulse: assert property (p_t1_pulse) else $error("timer1 pulse too long");
    property p_osc_hold; $fell(osc_enable) |-> $past(avs_write) || $past(avs_write, 2);
    endproperty
    a_osc_hold: assert property (p_osc_hold) else $error("osc stopped without write");
    c_t1: cover property (t1_count_en && sleep_mode);
    c_t0: cover property (t0_count_en);
    c_high: cover property (osc_range == 2'h3);
endmodule // cts_touch_sense_checker

bind cts_touch_sense cts_touch_sense_checker u_chk (.clk(clk), .rst_b(rst_b),
    .avs_write(avs_write), .sleep_mode(sleep_mode), .osc_enable(osc_enable),
    .osc_range(osc_range), .pad_select(pad_select), .t0_count_en(t0_count_en),
    .t1_count_en(t1_count_en));

// *** cts_pad_model.sv ***
module cts_pad_model (
    // from sensing block
    input wire logic osc_enable,
    input wire logic [1:0] osc_range,
    input wire logic [15:0] pad_select,
    input wire logic [15:0] half_ns,
    // oscillator seen at the pad
    output logic osc_in,
    output logic osc_phase_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // pad is analog input, so the ramp never stalls while the oscillator is enabled and routed
    initial begin
        osc_in = 1'b0;
        forever begin
            if (osc_enable === 1'b1 && pad_select != 16'h0) begin
                #(half_ns * (16'h4 - {14'h0, osc_range}));
                // a cut ramp must not leave a zero-width edge behind
                if (osc_enable === 1'b1 && pad_select != 16'h0) begin
                    osc_in = !osc_in;
                end
            end else begin
                osc_in = 1'b0;
                @(osc_enable or pad_select);
            end
        end
    end
    // sourcing while ramping up
    assign osc_phase_in = osc_in;
endmodule // cts_pad_model

// *** test_cts_touch_sense.sv ***
module test_cts_touch_sense;
    timeunit 1ns;
    timeprecision 1ns;
    import cts_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] b; logic [1:0] rng; logic [15:0] pad;} cts_row_type;
    logic clk, rst_b, clk_en, avs_read, avs_write, avs_waitrequest, wdt_overflow, sleep_mode;
    logic osc_in, osc_phase_in, osc_enable, t0_count_en, t1_count_en;
    logic [CTS_ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [1:0] avs_response, osc_range, resp;
    logic [15:0] pad_select, half_ns;
    int num_errors, total_checks, edge_cnt, saved;
    cts_row_type rows[5] = '{'{8'h0c, 8'h03, 2'h0, 16'h0}, '{8'h84, 8'h00, 2'h1, 16'h0001},
        '{8'h88, 8'h0f, 2'h2, 16'h8000}, '{8'h8d, 8'h07, 2'h3, 16'h0080},
        '{8'h80, 8'h05, 2'h0, 16'h0020}};
    cts_touch_sense u_cts_touch_sense (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .osc_in(osc_in),
        .osc_phase_in(osc_phase_in), .osc_enable(osc_enable), .osc_range(osc_range),
        .pad_select(pad_select), .sleep_mode(sleep_mode), .t0_ext_pin(1'b0),
        .t1_gate_pin(1'b0), .t0_overflow(1'b0), .t2_match(1'b0),
        .wdt_overflow(wdt_overflow), .t0_count_en(t0_count_en), .t1_count_en(t1_count_en));
    cts_pad_model u_cts_pad_model (.osc_enable(osc_enable), .osc_range(osc_range),
        .pad_select(pad_select), .half_ns(half_ns), .osc_in(osc_in),
        .osc_phase_in(osc_phase_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = !clk;
    end
    always @(posedge osc_in) edge_cnt++;
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic we, input logic [3:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= {idx, 2'h0};
        avs_write <= we;
        avs_read <= !we;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            num_errors++;
            end_sim();
        end
        q = avs_readdata;
        resp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // run the oscillator for a while, then stop it and let the syncs drain
    task automatic burst(input logic [7:0] on_a, input logic [7:0] off_a, input int cyc);
        bus(1'b1, CTS_IDX_SENSE_A, on_a);
        repeat (cyc) @(posedge clk);
        bus(1'b1, CTS_IDX_SENSE_A, off_a);
        repeat (10) @(posedge clk);
    endtask
    task automatic wdt_pulse();
        @(posedge clk);
        wdt_overflow <= 1'b1;
        @(posedge clk);
        wdt_overflow <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        {rst_b, avs_read, avs_write, wdt_overflow, sleep_mode} = 5'h0;
        avs_address = '0;
        clk_en = 1'b1;
        avs_writedata = 32'h0;
        half_ns = 16'd300;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, CTS_IDX_T0_OPT, 8'h0);
        chk("t0 option reset", q, {24'h0, CTS_T0_OPT_RESET});
        chk("pad reset", {16'h0, pad_select}, 32'h0);
        bus(1'b0, 4'h8, 8'h0);
        chk("unmapped response", {30'h0, resp}, 32'h2);
        bus(1'b1, CTS_IDX_SENSE_A, 8'h02);
        bus(1'b0, CTS_IDX_SENSE_A, 8'h0);
        chk("phase bit", q & 32'h2, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, CTS_IDX_SENSE_B, rows[i].b);
            bus(1'b1, CTS_IDX_SENSE_A, rows[i].a);
            repeat (3) @(negedge clk);
            chk("range", {30'h0, osc_range}, {30'h0, rows[i].rng});
            chk("pad", {16'h0, pad_select}, {16'h0, rows[i].pad});
            chk("osc enable", {31'h0, osc_enable}, {31'h0, rows[i].rng != 2'h0});
            bus(1'b0, CTS_IDX_SENSE_A, 8'h0);
            chk("control a", q & 32'h8d, {24'h0, rows[i].a & 8'h8d});
        end
        sleep_mode <= 1'b1;
        bus(1'b1, CTS_IDX_T1_GATE, 8'ha3);
        bus(1'b1, CTS_IDX_T1_CTRL, 8'hc1);
        bus(1'b1, CTS_IDX_T1_COUNT, 8'h0);
        wdt_pulse();
        edge_cnt = 0;
        burst(8'h8c, 8'h80, 200);
        wdt_pulse();
        bus(1'b0, CTS_IDX_T1_COUNT, 8'h0);
        chk("t1 count", q, edge_cnt);
        saved = edge_cnt;
        burst(8'h8c, 8'h80, 100);
        bus(1'b0, CTS_IDX_T1_COUNT, 8'h0);
        chk("t1 stopped", q, saved);
        sleep_mode <= 1'b0;
        half_ns = 16'd150;
        bus(1'b1, CTS_IDX_T0_OPT, 8'h0);
        bus(1'b1, CTS_IDX_T0_COUNT, 8'h0);
        edge_cnt = 0;
        burst(8'h8d, 8'h81, 200);
        bus(1'b0, CTS_IDX_T0_COUNT, 8'h0);
        chk("t0 count", q, edge_cnt & 32'hff);
        saved = edge_cnt;
        sleep_mode <= 1'b1;
        burst(8'h8d, 8'h81, 100);
        bus(1'b0, CTS_IDX_T0_COUNT, 8'h0);
        chk("t0 in sleep", q, saved & 32'hff);
        end_sim();
    end
endmodule // test_cts_touch_sense
